/* shared/irt_defs.svh */
// Purpose: offsets, fields, reset values and timing counts for the thermopile sensor block
// Assumes: sys_clk at 250 MHz
// Notes: link clock and data are sampled, not clocked on
`ifndef IRT_DEFS_SVH
`define IRT_DEFS_SVH
`define IRT_PTR_VOLT 8'h00
`define IRT_PTR_TEMP 8'h01
`define IRT_PTR_CFG 8'h02
`define IRT_PTR_MAKER 8'hfe
`define IRT_PTR_PART 8'hff
`define IRT_CFG_RESET 16'h7400
`define IRT_BIT_SWRST 15
`define IRT_MODE_HI 14
`define IRT_MODE_LO 12
`define IRT_RATE_HI 11
`define IRT_RATE_LO 9
`define IRT_BIT_PINEN 8
`define IRT_BIT_DONE 7
`define IRT_MODE_CONT 3'h7
`define IRT_RATE_MAX 3'h4
// one conversion slot per averaged sample: 250 ms of the 4 per second rate
`define IRT_SLOT_MS 250
`define IRT_CLK_KHZ 250000
`define IRT_SLOT_CYCLES (`IRT_SLOT_MS * `IRT_CLK_KHZ)
// conversion busy part of each slot, rest is low-power idle
`define IRT_CONV_US 25000
`define IRT_CONV_CYCLES (`IRT_CONV_US * (`IRT_CLK_KHZ / 1000))
`define IRT_I2C_ADDR_DEF 7'h40
`endif

/* shared/irt_pkg.sv */
// Purpose: types for the thermopile sensor block
// Assumes: nothing
// Notes: one-hot state codes
`default_nettype none
package irt_pkg;
  typedef enum logic [3:0] {
    IRT_CV_OFF = 4'h1,
    IRT_CV_BUSY = 4'h2,
    IRT_CV_IDLE = 4'h4,
    IRT_CV_RSV = 4'h8
  } irt_conv_t;
  typedef enum logic [5:0] {
    IRT_BS_IDLE = 6'h01,
    IRT_BS_ADDR = 6'h02,
    IRT_BS_ACK = 6'h04,
    IRT_BS_RX = 6'h08,
    IRT_BS_TX = 6'h10,
    IRT_BS_MACK = 6'h20
  } irt_bus_t;
endpackage
`default_nettype wire

/* design/irt_link.sv */
// Purpose: two-wire bus slave; pointer byte, 16-bit words MSB first
// Assumes: scl and sda sampled by sys_clk through two flip-flops
// Notes: gives word-level strobes to the register bank
`include "irt_defs.svh"
`default_nettype none
module irt_link (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [6:0] dev_addr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  output logic [7:0] ptr,
  output logic wr_word,
  output logic [15:0] wr_data,
  output logic rd_word,
  input wire logic [15:0] rd_data
);
  logic [1:0] scl_s, sda_s;
  logic [6:0] addr_s0, addr_s1;
  logic scl_d, sda_d;
  irt_pkg::irt_bus_t st;
  logic [3:0] bitn;
  logic [7:0] sh;
  logic [1:0] bidx;
  logic rw, hi_done;
  logic [7:0] hi_byte;
  logic [15:0] txw;
  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c = scl & scl_d & sda_d & ~sda;
  wire stop_c = scl & scl_d & ~sda_d & sda;
  wire [7:0] rx_byte = {sh[6:0], sda};
  wire addr_hit = sh[7:1] == addr_s1;
  always_ff @(posedge sys_clk) begin
    scl_s <= {scl_s[0], scl_in};
    sda_s <= {sda_s[0], sda_in};
    addr_s0 <= dev_addr;
    addr_s1 <= addr_s0;
    scl_d <= scl;
    sda_d <= sda;
  end
  always_ff @(posedge sys_clk) begin
    wr_word <= 1'b0;
    rd_word <= 1'b0;
    if (reset) begin
      st <= irt_pkg::IRT_BS_IDLE;
      sda_oe <= 1'b0;
      ptr <= 8'h00;
      wr_data <= 16'h0000;
      bitn <= 4'h0;
      sh <= 8'h00;
      bidx <= 2'h0;
      rw <= 1'b0;
      hi_done <= 1'b0;
      hi_byte <= 8'h00;
      txw <= 16'h0000;
    end else if (start_c) begin
      st <= irt_pkg::IRT_BS_ADDR;
      bitn <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      st <= irt_pkg::IRT_BS_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (st)
        irt_pkg::IRT_BS_IDLE: sda_oe <= 1'b0;
        irt_pkg::IRT_BS_ADDR, irt_pkg::IRT_BS_RX: begin
          if (scl_rise) begin
            sh <= rx_byte;
            bitn <= bitn + 4'h1;
          end
          if (scl_fall && bitn == 4'h8) begin
            bitn <= 4'h0;
            if (st == irt_pkg::IRT_BS_ADDR) begin
              if (addr_hit) begin
                rw <= sh[0];
                bidx <= 2'h0;
                hi_done <= 1'b0;
                sda_oe <= 1'b1;
                st <= irt_pkg::IRT_BS_ACK;
              end else begin
                st <= irt_pkg::IRT_BS_IDLE;
              end
            end else begin
              sda_oe <= 1'b1;
              st <= irt_pkg::IRT_BS_ACK;
              if (bidx == 2'h0) begin
                ptr <= sh;
              end else if (!hi_done) begin
                hi_byte <= sh;
                hi_done <= 1'b1;
              end else begin
                wr_data <= {hi_byte, sh};
                wr_word <= 1'b1;
                hi_done <= 1'b0;
              end
              if (bidx != 2'h3) begin
                bidx <= bidx + 2'h1;
              end
            end
          end
        end
        irt_pkg::IRT_BS_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              txw <= {rd_data[14:0], 1'b0};
              sda_oe <= ~rd_data[15];
              rd_word <= ~hi_done;
              if (hi_done) begin
                txw <= {txw[14:0], 1'b0};
                sda_oe <= ~txw[15];
              end
              bitn <= 4'h1;
              st <= irt_pkg::IRT_BS_TX;
            end else begin
              sda_oe <= 1'b0;
              st <= irt_pkg::IRT_BS_RX;
            end
          end
        end
        irt_pkg::IRT_BS_TX: begin
          if (scl_fall) begin
            if (bitn == 4'h8) begin
              sda_oe <= 1'b0;
              hi_done <= ~hi_done;
              st <= irt_pkg::IRT_BS_MACK;
            end else begin
              sda_oe <= ~txw[15];
              txw <= {txw[14:0], 1'b0};
              bitn <= bitn + 4'h1;
            end
          end
        end
        irt_pkg::IRT_BS_MACK: begin
          if (scl_rise) begin
            st <= sda ? irt_pkg::IRT_BS_IDLE : irt_pkg::IRT_BS_ACK;
          end
        end
        default: st <= irt_pkg::IRT_BS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* design/irt_sensor.sv */
// Purpose: register bank and conversion mode control of the thermopile sensor
// Assumes: converter results arrive as words with a one-cycle strobe
// Notes: bus reaches the registers through the pointer byte
`include "irt_defs.svh"
`default_nettype none
module irt_sensor #(
  parameter int unsigned SLOT_CYCLES = `IRT_SLOT_CYCLES,
  parameter int unsigned CONV_CYCLES = `IRT_CONV_CYCLES,
  parameter logic [15:0] MAKER_CODE = 16'h1234, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h0042 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [6:0] dev_addr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe,
  output logic sda_out,
  input wire logic adc_done,
  input wire logic [15:0] adc_volt,
  input wire logic [13:0] adc_temp,
  output logic adc_run,
  output logic adc_abort,
  output logic [4:0] adc_avg,
  output logic low_power,
  output logic ready_n_oe,
  output logic ready_n_out
);
  // ******************************
  // bus slave
  // ******************************
  logic [7:0] ptr;
  logic wr_word, rd_word, link_oe;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic soft_rst;
  wire blk_rst = reset | soft_rst;
  irt_link u_link (
    .sys_clk(sys_clk),
    .reset(blk_rst),
    .dev_addr(dev_addr),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe(link_oe),
    .ptr(ptr),
    .wr_word(wr_word),
    .wr_data(wr_data),
    .rd_word(rd_word),
    .rd_data(rd_data)
  );

  // ******************************
  // registers
  // ******************************
  logic [15:0] volt;
  logic [13:0] temp;
  logic [2:0] mode;
  logic [2:0] rate;
  logic pin_en;
  logic done_flag;
  irt_pkg::irt_conv_t cst;
  logic [31:0] cnt;
  logic [4:0] smp_left;

  function automatic logic [4:0] avg_of(input logic [2:0] r);
    logic [2:0] e;
    e = (r > `IRT_RATE_MAX) ? `IRT_RATE_MAX : r;
    return 5'(5'h01 << e);
  endfunction

  wire cfg_wr = wr_word && ptr == `IRT_PTR_CFG;
  wire res_rd = rd_word && (ptr == `IRT_PTR_VOLT || ptr == `IRT_PTR_TEMP);
  wire cont_mode = mode == `IRT_MODE_CONT;
  wire [15:0] cfg_word = {1'b0, mode, rate, pin_en, done_flag, 7'h00};
  wire last_smp = adc_done && cst == irt_pkg::IRT_CV_BUSY && smp_left == 5'h01;
  wire [4:0] next_avg = avg_of(rate);

  assign rd_data = (ptr == `IRT_PTR_VOLT) ? volt :
                   (ptr == `IRT_PTR_TEMP) ? {temp, 2'b00} :
                   (ptr == `IRT_PTR_CFG) ? cfg_word :
                   (ptr == `IRT_PTR_MAKER) ? MAKER_CODE :
                   (ptr == `IRT_PTR_PART) ? PART_CODE : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= cfg_wr & wr_data[`IRT_BIT_SWRST];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      mode <= 3'(`IRT_CFG_RESET >> `IRT_MODE_LO);
      rate <= 3'((`IRT_CFG_RESET >> `IRT_RATE_LO) & 16'h0007);
      pin_en <= 1'b0;
    end else if (cfg_wr) begin
      mode <= wr_data[`IRT_MODE_HI:`IRT_MODE_LO];
      rate <= wr_data[`IRT_RATE_HI:`IRT_RATE_LO];
      pin_en <= wr_data[`IRT_BIT_PINEN];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      volt <= 16'h0000;
      temp <= 14'h0000;
      done_flag <= 1'b0;
    end else begin
      if (last_smp && cont_mode && !cfg_wr) begin
        volt <= adc_volt;
        temp <= adc_temp;
      end
      if (last_smp && cont_mode && !cfg_wr) begin
        done_flag <= 1'b1;
      end else if (cfg_wr || res_rd) begin
        done_flag <= 1'b0;
      end
    end
  end

  // ******************************
  // conversion sequencer
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (blk_rst) begin
      cst <= irt_pkg::IRT_CV_OFF;
      cnt <= 32'h0;
      smp_left <= 5'h0;
    end else if (!cont_mode) begin
      cst <= irt_pkg::IRT_CV_OFF;
      cnt <= 32'h0;
    end else begin
      unique case (cst)
        irt_pkg::IRT_CV_OFF: begin
          cst <= irt_pkg::IRT_CV_BUSY;
          cnt <= 32'h0;
          smp_left <= next_avg;
        end
        irt_pkg::IRT_CV_BUSY: begin
          cnt <= cnt + 32'h1;
          if (adc_done) begin
            smp_left <= smp_left - 5'h1;
          end
          if (cnt >= 32'(CONV_CYCLES) * 32'(next_avg) || last_smp) begin
            cst <= irt_pkg::IRT_CV_IDLE;
          end
        end
        irt_pkg::IRT_CV_IDLE: begin
          cnt <= cnt + 32'h1;
          if (cnt >= 32'(SLOT_CYCLES) * 32'(next_avg) - 32'h1) begin
            cst <= irt_pkg::IRT_CV_BUSY;
            cnt <= 32'h0;
            smp_left <= next_avg;
          end
        end
        default: cst <= irt_pkg::IRT_CV_OFF;
      endcase
    end
  end

  // ******************************
  // outputs
  // ******************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      adc_run <= 1'b0;
      adc_abort <= 1'b0;
      adc_avg <= 5'h0;
      low_power <= 1'b1;
      ready_n_oe <= 1'b0;
      ready_n_out <= 1'b0;
    end else begin
      sda_oe <= link_oe;
      sda_out <= 1'b0;
      adc_run <= cst == irt_pkg::IRT_CV_BUSY && cont_mode;
      adc_abort <= cst == irt_pkg::IRT_CV_BUSY && !cont_mode;
      adc_avg <= next_avg;
      low_power <= cst != irt_pkg::IRT_CV_BUSY;
      ready_n_oe <= pin_en & done_flag;
      ready_n_out <= 1'b0;
    end
  end

  // ******************************
  // checks
  // ******************************
  a_swrst_clears: assert property (@(posedge sys_clk) disable iff (reset)
    soft_rst |=> (mode == 3'h7 && rate == 3'h2 && !pin_en && volt == 16'h0 && !done_flag))
    else $error("software reset did not restore registers");
  a_swrst_reads0: assert property (@(posedge sys_clk) disable iff (reset)
    rd_data[15] == 1'b0 || ptr != `IRT_PTR_CFG)
    else $error("reset bit read back as one");
  a_off_no_conv: assert property (@(posedge sys_clk) disable iff (reset)
    (!cont_mode && !blk_rst) |=> cst == irt_pkg::IRT_CV_OFF)
    else $error("conversion kept running in power-down");
  a_volt_hold_off: assert property (@(posedge sys_clk) disable iff (reset)
    (!cont_mode && !blk_rst) |=> $stable(volt))
    else $error("result changed in power-down");
  a_flag_clear_rd: assert property (@(posedge sys_clk) disable iff (reset)
    (res_rd && !last_smp) |=> !done_flag)
    else $error("data ready not cleared by result read");
  a_flag_set_done: assert property (@(posedge sys_clk) disable iff (reset)
    (last_smp && cont_mode && !cfg_wr && !blk_rst) |=> done_flag ##2 (ready_n_oe == pin_en))
    else $error("data ready not raised after conversion");
  a_pin_follows: assert property (@(posedge sys_clk) disable iff (reset)
    ready_n_oe == $past(pin_en & done_flag))
    else $error("ready pin disagrees with flag");
  a_temp_low0: assert property (@(posedge sys_clk) disable iff (reset)
    (ptr == `IRT_PTR_TEMP) |-> rd_data[1:0] == 2'b00)
    else $error("temperature low bits not zero");
  a_unused_zero: assert property (@(posedge sys_clk) disable iff (reset)
    (ptr == `IRT_PTR_CFG) |-> rd_data[6:0] == 7'h00)
    else $error("unused config bits not zero");
  a_ids_fixed: assert property (@(posedge sys_clk) disable iff (reset)
    (ptr == `IRT_PTR_PART) |-> rd_data == PART_CODE)
    else $error("part identity wrong");
  a_maker_fixed: assert property (@(posedge sys_clk) disable iff (reset)
    (ptr == `IRT_PTR_MAKER) |-> rd_data == MAKER_CODE)
    else $error("maker identity wrong");
  a_abort_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    adc_abort |=> !adc_abort)
    else $error("abort held longer than one cycle");
  a_run_not_lp: assert property (@(posedge sys_clk) disable iff (reset)
    adc_run |-> !low_power)
    else $error("low power while converting");
  a_rate_cap: assert property (@(posedge sys_clk) disable iff (reset)
    (rate >= `IRT_RATE_MAX) |-> next_avg == 5'h10)
    else $error("reserved rate not treated as slowest");
  a_temp_store: assert property (@(posedge sys_clk) disable iff (reset)
    (last_smp && cont_mode && !cfg_wr && !blk_rst) |=> temp == $past(adc_temp))
    else $error("temperature result not stored");
  a_flag_clear_wr: assert property (@(posedge sys_clk) disable iff (reset)
    (cfg_wr && !blk_rst) |=> !done_flag)
    else $error("data ready not cleared by config write");
  a_pin_disabled: assert property (@(posedge sys_clk) disable iff (reset)
    !pin_en |=> !ready_n_oe)
    else $error("ready pin driven while disabled");
  a_results_reset: assert property (@(posedge sys_clk) disable iff (reset)
    blk_rst |=> (volt == 16'h0000 && temp == 14'h0000))
    else $error("results not cleared by reset");
endmodule
`default_nettype wire

/* test/irt_host_model.sv */
// Purpose: two-wire bus host model for the sensor block
// Assumes: bit timing counted on sys_clk, 80 ns bus clock
// Notes: open drain; sda_low high pulls the data line low
`default_nettype none
module irt_host_model #(
  parameter logic [6:0] ADDR = 7'h40,
  parameter int HALF = 10
) (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // bus primitives
  // ************************************************
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // level set mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    wt(HALF / 2);
    sda_low = ~b;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF / 2);
    s = sda;
    wt(HALF / 2);
    scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, nack);
  endtask
  task automatic bus_start();
    wt(HALF);
    sda_low = 1'b1;
    wt(HALF);
    scl = 1'b0;
  endtask
  task automatic bus_stop();
    wt(HALF / 2);
    sda_low = 1'b1;
    wt(HALF / 2);
    scl = 1'b1;
    wt(HALF);
    sda_low = 1'b0;
    wt(HALF);
  endtask
  // pointer byte always follows the write address
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input logic data,
    output logic [3:0] nacks);
    logic [7:0] rx;
    logic n;
    bus_start();
    byte_io({ADDR, 1'b0}, 1'b1, rx, n);
    nacks = {3'h0, n};
    byte_io(ptr, 1'b1, rx, n);
    nacks = nacks + {3'h0, n};
    if (data) begin
      byte_io(d[15:8], 1'b1, rx, n);
      nacks = nacks + {3'h0, n};
      byte_io(d[7:0], 1'b1, rx, n);
      nacks = nacks + {3'h0, n};
    end
    bus_stop();
  endtask
  // read uses the kept pointer; msb acked, lsb not
  task automatic rd(output logic [15:0] d, output logic [3:0] nacks);
    logic [7:0] rx;
    logic n;
    bus_start();
    byte_io({ADDR, 1'b1}, 1'b1, rx, n);
    nacks = {3'h0, n};
    byte_io(8'hff, 1'b0, d[15:8], n);
    byte_io(8'hff, 1'b1, d[7:0], n);
    bus_stop();
  endtask
endmodule
`default_nettype wire

/* test/tb_irt_sensor.sv */
// Purpose: self-checking bench for the thermopile sensor register block
// Assumes: short slot counts; host model makes the bus clock
// Notes: a small converter model answers adc_run with sample pulses
`include "irt_defs.svh"
`default_nettype none
module tb_irt_sensor;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************
  // bench
  // ************************************************
  localparam logic [15:0] MAKER = 16'h5a3c; // arbitrary value
  localparam logic [15:0] PART = 16'h00c5; // arbitrary value
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic adc_done = 1'b0;
  logic [15:0] adc_volt = 16'h8123;
  logic [13:0] adc_temp = 14'h2abc;
  logic [6:0] dev_addr = 7'h40;
  int aborts = 0;
  logic [15:0] word;
  logic [15:0] rd_mask = 16'hffff;
  int budget = 0;
  int cnt = 0;
  int bad_count = 0;
  int checks_done = 0;
  logic sda_oe, sda_out, adc_run, adc_abort, low_power, ready_n_oe, ready_n_out;
  logic scl, host_low;
  logic [4:0] adc_avg;
  wire logic sda = ~(host_low | (sda_oe & ~sda_out));
  wire logic ready_n = ~(ready_n_oe & ~ready_n_out);
  irt_sensor #(.SLOT_CYCLES(2000), .CONV_CYCLES(1500), .MAKER_CODE(MAKER), .PART_CODE(PART)
  ) uut (.sys_clk(sys_clk), .reset(reset), .dev_addr(dev_addr), .scl_in(scl), .sda_in(sda),
    .sda_oe(sda_oe), .sda_out(sda_out), .adc_done(adc_done), .adc_volt(adc_volt),
    .adc_temp(adc_temp), .adc_run(adc_run), .adc_abort(adc_abort), .adc_avg(adc_avg),
    .low_power(low_power), .ready_n_oe(ready_n_oe), .ready_n_out(ready_n_out));
  irt_host_model host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(host_low));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // converter: a sample every 5 cycles while running, up to the budget
  always @(negedge sys_clk) begin
    adc_done = 1'b0;
    cnt = (adc_run === 1'b1 && budget > 0) ? cnt + 1 : 0;
    if (cnt == 5) begin
      adc_done = 1'b1;
      budget--;
      cnt = 0;
    end
  end
  always @(posedge sys_clk) begin
    if (adc_abort === 1'b1) begin
      aborts <= aborts + 1;
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] p, input logic [15:0] d, input logic data);
    logic [3:0] n;
    host.wr(p, d, data, n);
    chk("write nacks", 16'h0, {12'h0, n});
  endtask
  task automatic reg_rd(input string what, input logic [7:0] p, input logic [15:0] exp);
    logic [3:0] n;
    reg_wr(p, 16'h0, 1'b0);
    host.rd(word, n);
    chk("read nack", 16'h0, {12'h0, n});
    chk(what, exp & rd_mask, word & rd_mask);
  endtask
  task automatic wait_run(input logic lvl, input int bound);
    int i;
    for (i = 0; i < bound && adc_run !== lvl; i++) begin
      @(negedge sys_clk);
    end
    if (i == bound) begin
      bad_count++;
      $display("mismatch adc_run wait expected %b seen %b", lvl, adc_run);
      report_and_stop();
    end
  endtask
  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_reset();
    logic [3:0] n;
    reg_rd("temp", `IRT_PTR_TEMP, 16'h0000);
    reg_rd("volt", `IRT_PTR_VOLT, 16'h0000);
    dev_addr = 7'h41;
    host.wr(`IRT_PTR_CFG, 16'h0000, 1'b1, n);
    chk("foreign address nacks", 16'h4, {12'h0, n});
    dev_addr = 7'h40;
    reg_rd("config", `IRT_PTR_CFG, `IRT_CFG_RESET);
    reg_rd("maker", `IRT_PTR_MAKER, MAKER);
    host.rd(word, n);
    chk("maker again", MAKER, word);
    reg_rd("part", `IRT_PTR_PART, PART);
    reg_rd("unmapped", 8'h10, 16'h0000);
  endtask
  task automatic t_rates();
    logic [15:0] cfg;
    budget = 1000000;
    rd_mask = 16'hff7f;
    for (int r = 7; r >= 0; r--) begin
      cfg = {4'h7, 3'(r), 9'h0};
      reg_wr(`IRT_PTR_CFG, cfg, 1'b1);
      host.wt(20);
      chk("avg count", 16'(1 << (r > 4 ? 4 : r)), {11'h0, adc_avg});
      reg_rd("rate readback", `IRT_PTR_CFG, cfg);
    end
    rd_mask = 16'hffff;
  endtask
  task automatic t_convert();
    reg_wr(`IRT_PTR_CFG, 16'h0000, 1'b1);
    reg_wr(`IRT_PTR_CFG, 16'h7500, 1'b1);
    wait_run(1'b1, 9000);
    wait_run(1'b0, 100);
    host.wt(4);
    chk("ready pin set", 16'h0, {15'h0, ready_n});
    chk("idle low power", 16'h1, {15'h0, low_power});
    budget = 0;
    reg_rd("config done", `IRT_PTR_CFG, 16'h7580);
    reg_rd("temp", `IRT_PTR_TEMP, 16'haaf0);
    chk("ready pin clear", 16'h1, {15'h0, ready_n});
    reg_rd("volt", `IRT_PTR_VOLT, 16'h8123);
  endtask
  task automatic t_modes();
    int seen;
    adc_temp = 14'h0155;
    adc_volt = 16'h1357;
    for (int m = 0; m < 7; m++) begin
      budget = 1;
      reg_wr(`IRT_PTR_CFG, 16'h7200, 1'b1);
      wait_run(1'b1, 2500);
      seen = aborts;
      reg_wr(`IRT_PTR_CFG, {1'b0, 3'(m), 12'h0}, 1'b1);
      host.wt(4);
      chk("run after stop", 16'h0, {15'h0, adc_run});
      chk("abort seen", 16'h1, 16'(aborts - seen));
      chk("low power", 16'h1, {15'h0, low_power});
    end
    reg_rd("temp kept", `IRT_PTR_TEMP, 16'haaf0);
    reg_rd("volt kept", `IRT_PTR_VOLT, 16'h8123);
  endtask
  task automatic t_swreset();
    logic [3:0] n;
    budget = 1000000;
    reg_wr(`IRT_PTR_CFG, 16'h7400, 1'b1);
    wait_run(1'b1, 9000);
    wait_run(1'b0, 100);
    reg_wr(`IRT_PTR_CFG, 16'h75ff, 1'b1);
    reg_rd("config low bits", `IRT_PTR_CFG, 16'h7500);
    budget = 0;
    host.wr(`IRT_PTR_CFG, 16'hf500, 1'b1, n);
    chk("reset write nacks", 16'h1, {12'h0, n});
    reg_rd("config reset", `IRT_PTR_CFG, `IRT_CFG_RESET);
    reg_rd("temp reset", `IRT_PTR_TEMP, 16'h0000);
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_rates();
    t_convert();
    t_modes();
    t_swreset();
    report_and_stop();
  end
  initial begin
    #400us;
    bad_count++;
    $display("mismatch run time expected end seen timeout");
    report_and_stop();
  end
endmodule
`default_nettype wire
